// [core/aif_pkg.sv]
// Shared constants and types of the axis input filter and timing block
package aif_pkg;
	// Register byte offsets
	localparam logic [7:0] AIF_CONFIG_OFS  = 8'h00;
	localparam logic [7:0] AIF_RATE_OFS    = 8'h04;
	localparam logic [7:0] AIF_COMMAND_OFS = 8'h08;
	localparam logic [7:0] AIF_STATUS_OFS  = 8'h0c;
	localparam logic [7:0] AIF_INPUTS_OFS  = 8'h10;

	// Config fields
	localparam int AIF_CFG_W       = 9;
	localparam int AIF_CFG_ENC_B   = 0;
	localparam int AIF_CFG_HW_B    = 1;
	localparam int AIF_CFG_SNS_B   = 2;
	localparam int AIF_CFG_JOG_B   = 3;
	localparam int AIF_CFG_WID_LSB = 4;
	localparam int AIF_CFG_OFF_LSB = 7;
	localparam logic [AIF_CFG_W-1:0] AIF_CFG_RST  = 9'h000;
	localparam logic [15:0]          AIF_RATE_RST = 16'h0001;

	// Command bits
	localparam int AIF_CMD_SOFT_RESET_CMD_B  = 0;
	localparam int AIF_CMD_START_B = 1;
	localparam int AIF_CMD_SSTA_B  = 2;
	localparam int AIF_CMD_STOP_B  = 3;
	localparam int AIF_CMD_SSTP_B  = 4;
	localparam int AIF_CMD_DCLR_B  = 5;

	// Filter lanes
	localparam int AIF_LANES   = 22;
	localparam int AIF_FCW     = 20;
	localparam int AIF_L_ENC   = 0;
	localparam int AIF_L_HW    = 3;
	localparam int AIF_L_SNS   = 5;
	localparam int AIF_L_JOG   = 13;
	localparam int AIF_L_CLR   = 16;
	localparam int AIF_L_PCS   = 17;
	localparam int AIF_L_LTC   = 18;
	localparam int AIF_L_STA   = 19;
	localparam int AIF_L_STP   = 20;
	localparam int AIF_L_RST   = 21;
	// Active-low lines rest high
	localparam logic [AIF_LANES-1:0] AIF_LANE_INIT = 22'h380000;

	// Timing counts in reference clock cycles
	localparam int AIF_PASS_CYC   = 1;
	localparam int AIF_ENC_CYC    = 3;
	localparam int AIF_SNS_CYC    = 80;
	localparam int AIF_SYNC_CYC   = 5;
	localparam int AIF_RST_CYC    = 8;
	localparam int AIF_SOFT_RESET_CMD_CYC   = 12;
	localparam int AIF_DRIVE_CYC  = 8;
	localparam int AIF_SEQ_CMD    = 4;
	localparam int AIF_SEQ_SYNC   = 1;
	localparam int AIF_SEQ_BUSY   = 8;
	localparam int AIF_SEQ_PULSE  = 20;
	localparam int AIF_DCW0_CYC   = 240;
	localparam int AIF_DCW1_CYC   = 1920;
	localparam int AIF_DCO1_CYC   = 240;

	localparam int AIF_CW = 21;
	typedef logic [AIF_CW-1:0] aif_cnt_t;
	typedef enum logic [1:0] {AIF_DC_IDLE, AIF_DC_ON, AIF_DC_OFF} aif_dc_e;
endpackage : aif_pkg

// [core/aif_filt_if.sv]
// One input filter lane: raw level in, count threshold, clean level out
interface aif_filt_if;
	import aif_pkg::*;
	logic                raw;
	logic [AIF_FCW-1:0]  thresh;
	logic                clean;
	modport filt (input raw, input thresh, output clean);
	modport user (output raw, output thresh, input clean);
endinterface : aif_filt_if

// [core/aif_filter.sv]
// Stable-level digital noise filter for one input
module aif_filter
	import aif_pkg::*;
#(
	parameter logic INIT = 1'b0
)(
	input  wire logic  hclk,
	input  wire logic  hresetn,
	aif_filt_if.filt   f
);
	typedef struct packed {
		logic               samp;
		logic               out;
		logic [AIF_FCW-1:0] cnt;
	} aif_filt_s;

	aif_filt_s st_r;
	aif_filt_s st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.samp = f.raw;
		if (st_r.samp == st_r.out)
			st_nxt.cnt = '0;
		else if (st_r.cnt + 1'b1 >= f.thresh)
		begin
			st_nxt.out = st_r.samp;
			st_nxt.cnt = '0;
		end
		else
			st_nxt.cnt = st_r.cnt + 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_r <= '{samp: INIT, out: INIT, cnt: '0};
		else
			st_r <= st_nxt;
	end

	assign f.clean = st_r.out;
endmodule : aif_filter

// [core/axis_io_filter_timing.sv]
// Axis input conditioning, deviation-clear timing and start sequencing
module axis_io_filter_timing
	import aif_pkg::*;
#(
	parameter int DCW2_CYC = 7680,
	parameter int DCW3_CYC = 30720,
	parameter int DCW4_CYC = 245760,
	parameter int DCW5_CYC = 983040,
	parameter int DCW6_CYC = 1966080,
	parameter int DCO2_CYC = 30720,
	parameter int DCO3_CYC = 1966080,
	parameter int JOG_CYC  = 655360
)(
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic [31:0]               hrdata,
	output logic                      hresp,
	input  wire logic                 encoder_phase_a,
	input  wire logic                 encoder_phase_b,
	input  wire logic                 encoder_zero_in,
	input  wire logic                 handwheel_phase_a,
	input  wire logic                 handwheel_phase_b,
	input  wire logic                 plus_end_limit,
	input  wire logic                 minus_end_limit,
	input  wire logic [1:0]           slowdown_sensor,
	input  wire logic                 origin_sensor,
	input  wire logic                 alarm_in,
	input  wire logic                 in_position_in,
	input  wire logic                 emergency_stop_in,
	input  wire logic                 jog_plus_in,
	input  wire logic                 jog_minus_in,
	input  wire logic                 jog_enable_in,
	input  wire logic                 counter_clear_in,
	input  wire logic                 positioning_counter_start_in,
	input  wire logic                 counter_latch_in,
	input  wire logic                 sync_start_line_n,
	input  wire logic                 sync_stop_line_n,
	input  wire logic                 reset_pin_n,
	output logic [AIF_LANES-1:0]      filtered_inputs,
	output logic                      counter_clear_pulse,
	output logic                      count_start_pulse,
	output logic                      counter_latch_pulse,
	output logic                      deviation_clear_out,
	output logic                      busy_out,
	output logic                      pulse_out,
	output logic                      sync_start_out,
	output logic                      sync_start_oe_n,
	output logic                      sync_stop_out,
	output logic                      sync_stop_oe_n
);
	import aif_pkg::*;

	typedef struct packed {
		logic                 a_vld;
		logic                 a_wr;
		logic [7:0]           a_ofs;
		logic                 rdy;
		logic [31:0]          rdata;
		logic [AIF_CFG_W-1:0] cfg;
		logic [15:0]          rate;
		logic                 soft_reset_cmd_act;
		logic [3:0]           soft_reset_cmd_cnt;
		logic                 seq_act;
		logic [4:0]           seq_cnt;
		logic                 run;
		logic                 busy;
		logic [15:0]          ph;
		logic                 pulse;
		aif_dc_e              dc_st;
		aif_cnt_t             dc_cnt;
		logic                 dc_out;
		logic [3:0]           sta_cnt;
		logic [3:0]           stp_cnt;
		logic                 sta_prev;
		logic                 stp_prev;
		logic [2:0]           lvl_prev;
		logic [2:0]           edges;
	} aif_top_s;

	aif_top_s                            st_r;
	aif_top_s                            st_nxt;
	logic [AIF_LANES-1:0]                raw;
	logic [AIF_LANES-1:0]                clean;
	logic [AIF_LANES-1:0][AIF_FCW-1:0]   thr;
	logic [5:0]                          cmd;
	logic                                go_cmd;
	logic                                go_sync;
	logic [15:0]                         period;

	assign raw = {reset_pin_n, sync_stop_line_n, sync_start_line_n, counter_latch_in,
		positioning_counter_start_in, counter_clear_in, jog_enable_in, jog_minus_in,
		jog_plus_in, emergency_stop_in, in_position_in, alarm_in, origin_sensor,
		slowdown_sensor, minus_end_limit, plus_end_limit, handwheel_phase_b,
		handwheel_phase_a, encoder_zero_in, encoder_phase_b, encoder_phase_a};

	// Thresholds are counts of stable cycles; one cycle means pass-through
	always_comb
	begin
		for (int i = 0; i < AIF_LANES; i++)
		begin
			if (i < AIF_L_HW)
				thr[i] = AIF_FCW'(st_r.cfg[AIF_CFG_ENC_B] ? AIF_ENC_CYC : AIF_PASS_CYC);
			else if (i < AIF_L_SNS)
				thr[i] = AIF_FCW'(st_r.cfg[AIF_CFG_HW_B] ? AIF_ENC_CYC : AIF_PASS_CYC);
			else if (i < AIF_L_JOG)
				thr[i] = AIF_FCW'(st_r.cfg[AIF_CFG_SNS_B] ? AIF_SNS_CYC : AIF_PASS_CYC);
			else if (i < AIF_L_CLR)
				thr[i] = AIF_FCW'(st_r.cfg[AIF_CFG_JOG_B] ? JOG_CYC : AIF_PASS_CYC);
			else if (i < AIF_L_STA)
				thr[i] = AIF_FCW'(AIF_PASS_CYC);
			else if (i < AIF_L_RST)
				thr[i] = AIF_FCW'(AIF_SYNC_CYC);
			else
				thr[i] = AIF_FCW'(AIF_RST_CYC);
		end
	end

	// Each lane filters independently
	for (genvar g = 0; g < AIF_LANES; g++)
	begin : g_lane
		aif_filt_if fi ();
		assign fi.raw = raw[g];
		assign fi.thresh = thr[g];
		assign clean[g] = fi.clean;
		aif_filter #(.INIT(AIF_LANE_INIT[g])) u_filt (
			.hclk    (hclk),
			.hresetn (hresetn),
			.f       (fi)
		);
	end

	function automatic aif_cnt_t on_width(input logic [2:0] code);
		unique case (code)
			3'h0: on_width = AIF_CW'(AIF_DCW0_CYC);
			3'h1: on_width = AIF_CW'(AIF_DCW1_CYC);
			3'h2: on_width = AIF_CW'(DCW2_CYC);
			3'h3: on_width = AIF_CW'(DCW3_CYC);
			3'h4: on_width = AIF_CW'(DCW4_CYC);
			3'h5: on_width = AIF_CW'(DCW5_CYC);
			3'h6: on_width = AIF_CW'(DCW6_CYC);
			default: on_width = AIF_CW'(AIF_DCW0_CYC);
		endcase
	endfunction : on_width

	function automatic aif_cnt_t off_time(input logic [1:0] code);
		unique case (code)
			2'h0: off_time = '0;
			2'h1: off_time = AIF_CW'(AIF_DCO1_CYC);
			2'h2: off_time = AIF_CW'(DCO2_CYC);
			2'h3: off_time = AIF_CW'(DCO3_CYC);
		endcase
	endfunction : off_time

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rdy = 1'b1;
		// Zero-wait slave: read data is latched in the address phase
		st_nxt.a_vld = hsel && htrans[1] && hready;
		st_nxt.a_wr = hwrite;
		st_nxt.a_ofs = haddr[7:0];
		if (hsel && htrans[1] && hready && !hwrite)
		begin
			unique case (haddr[7:0])
				AIF_CONFIG_OFS: st_nxt.rdata = 32'(st_r.cfg);
				AIF_RATE_OFS:   st_nxt.rdata = 32'(st_r.rate);
				AIF_STATUS_OFS: st_nxt.rdata = 32'({st_r.run, st_r.dc_out, st_r.soft_reset_cmd_act,
					st_r.busy});
				AIF_INPUTS_OFS: st_nxt.rdata = 32'(clean);
				default:        st_nxt.rdata = 32'h0000_0000;
			endcase
		end
		cmd = '0;
		if (st_r.a_vld && st_r.a_wr)
		begin
			unique case (st_r.a_ofs)
				AIF_CONFIG_OFS:  st_nxt.cfg = hwdata[AIF_CFG_W-1:0];
				AIF_RATE_OFS:    st_nxt.rate = hwdata[15:0];
				AIF_COMMAND_OFS: cmd = hwdata[5:0];
				default:         ;
			endcase
		end

		// One-cycle pulses on rising filtered edges
		st_nxt.lvl_prev = clean[AIF_L_LTC:AIF_L_CLR];
		st_nxt.edges = clean[AIF_L_LTC:AIF_L_CLR] & ~st_r.lvl_prev;

		// Soft reset: internal state held clear, done after 12 cycles
		if (cmd[AIF_CMD_SOFT_RESET_CMD_B])
		begin
			st_nxt.soft_reset_cmd_act = 1'b1;
			st_nxt.soft_reset_cmd_cnt = 4'(AIF_SOFT_RESET_CMD_CYC - 1);
		end
		else if (st_r.soft_reset_cmd_act)
		begin
			st_nxt.soft_reset_cmd_cnt = st_r.soft_reset_cmd_cnt - 4'h1;
			st_nxt.soft_reset_cmd_act = (st_r.soft_reset_cmd_cnt != 4'h1);
		end

		// Sync line drives: held low for 8 cycles
		st_nxt.sta_prev = clean[AIF_L_STA];
		st_nxt.stp_prev = clean[AIF_L_STP];
		if (cmd[AIF_CMD_SSTA_B])
			st_nxt.sta_cnt = 4'(AIF_DRIVE_CYC);
		else if (st_r.sta_cnt != 4'h0)
			st_nxt.sta_cnt = st_r.sta_cnt - 4'h1;
		if (cmd[AIF_CMD_SSTP_B])
			st_nxt.stp_cnt = 4'(AIF_DRIVE_CYC);
		else if (st_r.stp_cnt != 4'h0)
			st_nxt.stp_cnt = st_r.stp_cnt - 4'h1;

		// Start sequencer; sync path enters three counts lower
		go_cmd = cmd[AIF_CMD_START_B] && !st_r.seq_act && !st_r.run && !st_r.soft_reset_cmd_act;
		go_sync = st_r.sta_prev && !clean[AIF_L_STA] && !st_r.seq_act && !st_r.run
			&& !st_r.soft_reset_cmd_act;
		period = (st_r.rate == 16'h0000) ? 16'h0002 : st_r.rate + 16'h0001;
		if (go_cmd || go_sync)
		begin
			st_nxt.seq_act = 1'b1;
			st_nxt.seq_cnt = go_cmd ? 5'(AIF_SEQ_CMD) : 5'(AIF_SEQ_SYNC);
		end
		else if (st_r.seq_act)
		begin
			st_nxt.seq_cnt = st_r.seq_cnt + 5'h01;
			if (st_nxt.seq_cnt == 5'(AIF_SEQ_BUSY))
				st_nxt.busy = 1'b1;
			if (st_nxt.seq_cnt == 5'(AIF_SEQ_PULSE))
			begin
				st_nxt.seq_act = 1'b0;
				st_nxt.run = 1'b1;
				st_nxt.ph = '0;
			end
		end
		else if (st_r.run)
			st_nxt.ph = (st_r.ph + 16'h0001 >= period) ? 16'h0000 : st_r.ph + 16'h0001;
		// On-time is half the period rounded down
		st_nxt.pulse = st_nxt.run && (st_nxt.ph < (period >> 1));
		if (cmd[AIF_CMD_STOP_B] || (st_r.stp_prev && !clean[AIF_L_STP]))
		begin
			st_nxt.seq_act = 1'b0;
			st_nxt.run = 1'b0;
			st_nxt.busy = 1'b0;
			st_nxt.pulse = 1'b0;
		end

		// Deviation-clear pulse, then a dead time before the next
		unique case (st_r.dc_st)
			AIF_DC_IDLE:
				if (cmd[AIF_CMD_DCLR_B])
				begin
					st_nxt.dc_st = AIF_DC_ON;
					st_nxt.dc_out = 1'b1;
					st_nxt.dc_cnt = on_width(st_r.cfg[AIF_CFG_WID_LSB +: 3]) - 1'b1;
				end
			AIF_DC_ON:
				if (st_r.dc_cnt != '0)
					st_nxt.dc_cnt = st_r.dc_cnt - 1'b1;
				else
				begin
					st_nxt.dc_out = 1'b0;
					st_nxt.dc_cnt = off_time(st_r.cfg[AIF_CFG_OFF_LSB +: 2]);
					st_nxt.dc_st = AIF_DC_OFF;
				end
			AIF_DC_OFF:
				if (st_r.dc_cnt > AIF_CW'(1))
					st_nxt.dc_cnt = st_r.dc_cnt - 1'b1;
				else
					st_nxt.dc_st = AIF_DC_IDLE;
			default: st_nxt.dc_st = AIF_DC_IDLE;
		endcase

		if (st_r.soft_reset_cmd_act || !clean[AIF_L_RST])
		begin
			st_nxt.seq_act = 1'b0;
			st_nxt.run = 1'b0;
			st_nxt.busy = 1'b0;
			st_nxt.pulse = 1'b0;
			st_nxt.dc_st = AIF_DC_IDLE;
			st_nxt.dc_out = 1'b0;
			st_nxt.sta_cnt = '0;
			st_nxt.stp_cnt = '0;
		end
		// Reset pin also restores configuration
		if (!clean[AIF_L_RST])
		begin
			st_nxt.cfg = AIF_CFG_RST;
			st_nxt.rate = AIF_RATE_RST;
			st_nxt.soft_reset_cmd_act = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r <= '0;
			st_r.cfg <= AIF_CFG_RST;
			st_r.rate <= AIF_RATE_RST;
			st_r.sta_prev <= 1'b1;
			st_r.stp_prev <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign hreadyout = st_r.rdy;
	assign hrdata = st_r.rdata;
	assign hresp = 1'b0;
	assign filtered_inputs = clean;
	assign {counter_latch_pulse, count_start_pulse, counter_clear_pulse} = st_r.edges;
	assign deviation_clear_out = st_r.dc_out;
	assign busy_out = st_r.busy;
	assign pulse_out = st_r.pulse;
	assign sync_start_out = 1'b0;
	assign sync_stop_out = 1'b0;
	assign sync_start_oe_n = (st_r.sta_cnt == 4'h0);
	assign sync_stop_oe_n = (st_r.stp_cnt == 4'h0);

	// Stop, soft reset or reset pin legally cut a start sequence short
	logic seq_halt;
	assign seq_halt = cmd[AIF_CMD_STOP_B] || (st_r.stp_prev && !clean[AIF_L_STP])
		|| st_r.soft_reset_cmd_act || !clean[AIF_L_RST];

	// Helper: running length of the current deviation-clear pulse
	aif_cnt_t dc_len;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dc_len <= '0;
		else
			dc_len <= st_r.dc_out ? dc_len + 1'b1 : '0;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_busy_cmd_lat: assert property (disable iff (!hresetn || seq_halt)
		go_cmd && !cmd[AIF_CMD_STOP_B] && clean[AIF_L_RST]
		|=> !busy_out [*4] ##1 busy_out) else $error("busy latency after command");
	a_busy_sync_lat: assert property (disable iff (!hresetn || seq_halt)
		go_sync && !cmd[AIF_CMD_STOP_B] && clean[AIF_L_RST]
		|=> !busy_out [*7] ##1 busy_out) else $error("busy latency after sync");
	a_pulse_cmd_lat: assert property (disable iff (!hresetn || seq_halt)
		go_cmd && !cmd[AIF_CMD_STOP_B] && clean[AIF_L_RST]
		|-> ##17 (pulse_out && !$past(pulse_out))) else $error("first pulse late");
	a_pulse_sync_lat: assert property (disable iff (!hresetn || seq_halt)
		go_sync && !cmd[AIF_CMD_STOP_B] && clean[AIF_L_RST]
		|-> ##20 (pulse_out && !$past(pulse_out))) else $error("sync pulse late");
	a_soft_reset_cmd_done_time: assert property (cmd[AIF_CMD_SOFT_RESET_CMD_B] && clean[AIF_L_RST]
		|-> ##11 st_r.soft_reset_cmd_act ##1 !st_r.soft_reset_cmd_act) else $error("soft reset time");
	a_clear_on_width: assert property ($fell(deviation_clear_out) && clean[AIF_L_RST]
		&& !$past(st_r.soft_reset_cmd_act) |-> dc_len == on_width($past(st_r.cfg[AIF_CFG_WID_LSB +: 3]))
		&& $past(dc_len) + 1'b1 == dc_len) else $error("clear width");
	a_sync_start_hold: assert property ($fell(sync_start_oe_n) && clean[AIF_L_RST]
		&& !st_r.soft_reset_cmd_act |-> !sync_start_oe_n [*8]) else $error("start drive short");
	a_sync_stop_hold: assert property ($fell(sync_stop_oe_n) && clean[AIF_L_RST]
		&& !st_r.soft_reset_cmd_act |-> !sync_stop_oe_n [*8]) else $error("stop drive short");
endmodule : axis_io_filter_timing

// [dv/aif_field_model.sv]
// Field-side model: sensors, encoders, jog inputs and the wired sync lines
module aif_field_model
	import aif_pkg::*;
(
	input  wire logic                 hclk,
	input  wire logic                 req,
	input  wire logic [4:0]           lane,
	input  wire logic [20:0]          width,
	input  wire logic                 sync_start_oe_n,
	input  wire logic                 sync_stop_oe_n,
	output logic [AIF_LANES-1:0]      lines
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [AIF_LANES-1:0] act;
	int                   left;
	initial
	begin
		act = '0;
		left = 0;
	end
	// Pulse held exactly as long as asked, the reset pin included
	always @(posedge hclk)
	begin
		if (req)
		begin
			act <= AIF_LANES'(1) << lane;
			left <= int'(width);
		end
		else if (left > 1)
			left <= left - 1;
		else
		begin
			act <= '0;
			left <= 0;
		end
	end
	// Pull-up on the wired lines: released means high, any driver pulls low
	always_comb
	begin
		lines = AIF_LANE_INIT ^ act;
		lines[AIF_L_STA] = lines[AIF_L_STA] & sync_start_oe_n;
		lines[AIF_L_STP] = lines[AIF_L_STP] & sync_stop_oe_n;
	end
endmodule : aif_field_model

// [dv/axis_io_filter_timing_tb_top.sv]
// Self-checking bench of the axis input filter and timing block
module axis_io_filter_timing_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import aif_pkg::*;
	localparam int JOG     = 16;
	localparam int DCW [7] = '{240, 1920, 20, 24, 28, 32, 36};
	localparam int DCO [4] = '{0, 240, 24, 40};
	logic                 hclk, hresetn, hwrite, hreadyout, hresp, req, acc_clr;
	logic [31:0]          haddr, hwdata, hrdata;
	logic [1:0]           htrans;
	logic [4:0]           lane;
	logic [20:0]          width;
	logic [AIF_LANES-1:0] lines, filtered_inputs;
	logic                 counter_clear_pulse, count_start_pulse, counter_latch_pulse;
	logic                 deviation_clear_out, busy_out, pulse_out;
	logic                 sync_start_out, sync_start_oe_n, sync_stop_out, sync_stop_oe_n;
	logic [24:0]          acc;
	logic                 bq, pq, dq, sq, first;
	int                   failures, compares, cyc, wr_cyc, busy_cyc, pls_cyc, fall_cyc;
	int                   dc_n, dc_w, hi_n, lo_n, hi_w, lo_w, oe_n, oe_w, t, rate;
	logic [3:0]           cfg;

	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	axis_io_filter_timing #(.DCW2_CYC(DCW[2]), .DCW3_CYC(DCW[3]), .DCW4_CYC(DCW[4]),
		.DCW5_CYC(DCW[5]), .DCW6_CYC(DCW[6]), .DCO2_CYC(DCO[2]), .DCO3_CYC(DCO[3]),
		.JOG_CYC(JOG)) i_dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
		.encoder_phase_a(lines[0]), .encoder_phase_b(lines[1]), .encoder_zero_in(lines[2]),
		.handwheel_phase_a(lines[3]), .handwheel_phase_b(lines[4]),
		.plus_end_limit(lines[5]), .minus_end_limit(lines[6]), .slowdown_sensor(lines[8:7]),
		.origin_sensor(lines[9]), .alarm_in(lines[10]), .in_position_in(lines[11]),
		.emergency_stop_in(lines[12]), .jog_plus_in(lines[13]), .jog_minus_in(lines[14]),
		.jog_enable_in(lines[15]), .counter_clear_in(lines[16]),
		.positioning_counter_start_in(lines[17]), .counter_latch_in(lines[18]),
		.sync_start_line_n(lines[19]), .sync_stop_line_n(lines[20]), .reset_pin_n(lines[21]),
		.filtered_inputs, .counter_clear_pulse, .count_start_pulse, .counter_latch_pulse,
		.deviation_clear_out, .busy_out, .pulse_out, .sync_start_out, .sync_start_oe_n,
		.sync_stop_out, .sync_stop_oe_n);

	aif_field_model i_field (.hclk, .req, .lane, .width, .sync_start_oe_n, .sync_stop_oe_n,
		.lines);

	// Event stamps use the pre-edge cycle count so bus and monitor agree
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		acc <= acc_clr ? 25'h0 : acc | {counter_latch_pulse, count_start_pulse,
			counter_clear_pulse, filtered_inputs ^ AIF_LANE_INIT};
		bq <= busy_out;
		pq <= pulse_out;
		dq <= deviation_clear_out;
		sq <= filtered_inputs[AIF_L_STA];
		if (busy_out && !bq)
			busy_cyc <= cyc;
		if (!busy_out)
			first <= 1'b1;
		else if (pulse_out && !pq && first)
		begin
			pls_cyc <= cyc;
			first <= 1'b0;
		end
		if (!filtered_inputs[AIF_L_STA] && sq)
			fall_cyc <= cyc;
		dc_n <= deviation_clear_out ? dc_n + 1 : 0;
		if (!deviation_clear_out && dq)
			dc_w <= dc_n;
		hi_n <= pulse_out ? hi_n + 1 : 0;
		lo_n <= pulse_out ? 0 : lo_n + 1;
		if (!pulse_out && pq)
			hi_w <= hi_n;
		if (pulse_out && !pq)
			lo_w <= lo_n;
		oe_n <= (sync_start_oe_n && sync_stop_oe_n) ? 0 : oe_n + 1;
		if (sync_start_oe_n && sync_stop_oe_n && oe_n > 0)
			oe_w <= oe_n;
		if (cyc == 40000)
		begin
			failures++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : check

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
		wr_cyc = cyc;
		// Idle gap refreshes status longer settle after writes
		repeat (w ? 3 : 1) @(posedge hclk);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, exp, what);
		check(32'({hresp, sync_start_out, sync_stop_out}), 32'h0, "fixed outputs");
	endtask : rd_chk

	task automatic field_pulse(input int l, input int w);
		lane <= 5'(l);
		width <= 21'(w);
		req <= 1'b1;
		@(posedge hclk);
		req <= 1'b0;
	endtask : field_pulse

	function automatic int thr(input int l, input logic [3:0] c);
		if (l < AIF_L_HW) return c[0] ? AIF_ENC_CYC : 1;
		if (l < AIF_L_SNS) return c[1] ? AIF_ENC_CYC : 1;
		if (l < AIF_L_JOG) return c[2] ? AIF_SNS_CYC : 1;
		if (l < AIF_L_CLR) return c[3] ? JOG : 1;
		if (l < AIF_L_STA) return 1;
		if (l < AIF_L_RST) return AIF_SYNC_CYC;
		return AIF_RST_CYC;
	endfunction : thr

	initial
	begin
		{hresetn, hwrite, req, haddr, hwdata, htrans, lane, width} = '0;
		acc_clr = 1'b1;
		void'($urandom(32'h03e91759));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(AIF_CONFIG_OFS, 32'h0, "config reset");
		rd_chk(AIF_RATE_OFS, 32'h1, "rate reset");
		rd_chk(AIF_COMMAND_OFS, 32'h0, "command read");
		rd_chk(8'h40, 32'h0, "unmapped read");
		rd_chk(AIF_INPUTS_OFS, 32'(AIF_LANE_INIT), "inputs idle");
		$display("test registers done");
		for (int l = 0; l < AIF_LANES; l++)
			for (int c = 0; c < 2; c++)
			begin
				cfg = c ? 4'hf : 4'h0;
				wr(AIF_CONFIG_OFS, {28'h0, cfg});
				t = thr(l, cfg);
				for (int w = t - 1; w <= t; w++)
					if (w > 0)
					begin
						acc_clr <= 1'b1;
						@(posedge hclk);
						acc_clr <= 1'b0;
						field_pulse(l, w);
						repeat (w + t + 6) @(posedge hclk);
						check(32'(acc[l]), 32'(w >= t), "filter");
						if (l >= AIF_L_CLR && l < AIF_L_STA)
							check(32'(acc[l + 6]), 32'h1, "input pulse");
						wr(AIF_COMMAND_OFS, 32'h8);
					end
			end
		$display("test filters done");
		wr(AIF_COMMAND_OFS, 32'h1);
		repeat (7) @(posedge hclk);
		rd_chk(AIF_STATUS_OFS, 32'h2, "soft reset running");
		rd_chk(AIF_STATUS_OFS, 32'h0, "soft reset over");
		$display("test soft reset done");
		for (int i = 0; i < 3; i++)
		begin
			rate = 2 + int'($urandom_range(7));
			wr(AIF_RATE_OFS, 32'(rate));
			wr(AIF_COMMAND_OFS, 32'h2);
			repeat (30 + 4 * rate) @(posedge hclk);
			check(32'(busy_cyc - wr_cyc - 1 inside {[4:5]}), 32'h1, "busy delay");
			check(32'(pls_cyc - wr_cyc - 1 inside {[16:17]}), 32'h1, "start delay");
			check(32'(hi_w), 32'((rate + 1) / 2), "pulse on");
			check(32'(lo_w), 32'(rate + 1 - (rate + 1) / 2), "pulse off");
			wr(AIF_COMMAND_OFS, 32'h8);
		end
		field_pulse(AIF_L_STA, AIF_SYNC_CYC);
		repeat (40) @(posedge hclk);
		check(32'(busy_cyc - fall_cyc inside {[7:8]}), 32'h1, "sync busy delay");
		check(32'(pls_cyc - fall_cyc inside {[19:20]}), 32'h1, "sync start delay");
		field_pulse(AIF_L_STP, AIF_SYNC_CYC);
		repeat (12) @(posedge hclk);
		check(32'(busy_out), 32'h0, "sync stop");
		wr(AIF_COMMAND_OFS, 32'h4);
		repeat (40) @(posedge hclk);
		check(32'(oe_w >= AIF_DRIVE_CYC), 32'h1, "start drive");
		check(32'(busy_out), 32'h1, "self start");
		wr(AIF_COMMAND_OFS, 32'h10);
		repeat (20) @(posedge hclk);
		check(32'(oe_w >= AIF_DRIVE_CYC), 32'h1, "stop drive");
		check(32'(busy_out), 32'h0, "self stop");
		$display("test start stop done");
		for (int k = 0; k < 7; k++)
		begin
			wr(AIF_CONFIG_OFS, 32'((k << 4) | ((k % 4) << 7)));
			wr(AIF_COMMAND_OFS, 32'h20);
			repeat (DCW[k] + 2) @(posedge hclk);
			check(32'(dc_w), 32'(DCW[k]), "clear width");
			wr(AIF_COMMAND_OFS, 32'h20);
			repeat (2) @(posedge hclk);
			check(32'(deviation_clear_out), 32'(k % 4 == 0), "clear off time");
			repeat (DCW[k] + DCO[k % 4] + 4) @(posedge hclk);
		end
		$display("test deviation clear done");
		wr(AIF_CONFIG_OFS, 32'h1ff);
		field_pulse(AIF_L_RST, AIF_RST_CYC - 1);
		repeat (12) @(posedge hclk);
		rd_chk(AIF_CONFIG_OFS, 32'h1ff, "short reset pin");
		field_pulse(AIF_L_RST, AIF_RST_CYC);
		repeat (12) @(posedge hclk);
		rd_chk(AIF_CONFIG_OFS, 32'h0, "reset pin");
		$display("test reset pin done");
		stop_test();
	end
endmodule : axis_io_filter_timing_tb_top
